/* include/cfcs_defines.vh */
// Purpose: constants for the code flash cache and sequencer
// Assumes: 50 MHz core clock, 32-bit register port
// Notes: register offsets are byte addresses on the register port
`ifndef CFCS_DEFINES_VH
`define CFCS_DEFINES_VH
// ********************************************************
// Register map
// ********************************************************
`define CFCS_REG_CTRL 8'h00
`define CFCS_REG_ENTRY 8'h04
`define CFCS_REG_ASTAT 8'h08
`define CFCS_REG_AIRQ 8'h0c
`define CFCS_REG_STAT 8'h10
`define CFCS_REG_IRQST 8'h14
`define CFCS_REG_IRQMSK 8'h18
`define CFCS_REG_UID0 8'h20
`define CFCS_UID_WORDS 4
// ********************************************************
// Fields
// ********************************************************
`define CFCS_CTRL_CEN 0
`define CFCS_CTRL_CINV 1
`define CFCS_CTRL_START1 2
`define CFCS_CTRL_TMEN 3
`define CFCS_ENTRY_BIT 0
`define CFCS_KEY_HI 15
`define CFCS_KEY_LO 8
`define CFCS_ENTRY_KEY 8'haa
`define CFCS_VIOL_BIT 7
`define CFCS_IRQ_DONE 0
`define CFCS_IRQ_VIOL 1
// ********************************************************
// Flash map and sequencer
// ********************************************************
`define CFCS_CMD_AREA 24'h7e0000
`define CFCS_CMD_PROG 8'he8
`define CFCS_CMD_ERASE 8'h20
`define CFCS_CMD_SUSPEND 8'hb0
`define CFCS_CMD_RESUME 8'hd0
`define CFCS_PROG_BYTES 128
`define CFCS_BLOCK_SHIFT 13
`define CFCS_CLK_MHZ 50
`define CFCS_LINE_BYTES 16
`define CFCS_CACHE_BYTES 256
`define CFCS_SET_BIT 4
`define CFCS_MHZ_LOW 50
`define CFCS_MHZ_HIGH 100
`define CFCS_TM_BLK_LO 7'd8
`define CFCS_TM_BLK_HI 7'd9
`define CFCS_REG_UID1 8'h24
`define CFCS_REG_UID2 8'h28
`define CFCS_REG_UID3 8'h2c
`endif

/* hdl/cfcs_top.v */
// Purpose: code flash read cache, command sequencer, protection, ID
// Assumes: flash array answers line reads with fixed latency by stall
// Notes: one clock domain; ce low freezes every flip-flop
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "cfcs_defines.vh"
module cfcs_top #(
  parameter CLK_MHZ = `CFCS_CLK_MHZ,
  parameter WAYS = 8,
  parameter PROG_CYCLES = 2000,
  parameter ERASE_CYCLES = 4000,
  parameter [127:0] UNIQUE_ID = 128'h0123456789abcdeffedcba9876543210
) (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire fetch_req,
  input wire [19:0] fetch_addr,
  output wire fetch_ready,
  output reg [31:0] fetch_data,
  output reg fetch_valid,
  input wire cmd_wr,
  input wire [23:0] cmd_addr,
  input wire [7:0] cmd_data,
  input wire trusted_auth,
  output reg flash_line_rd,
  output reg [15:0] flash_line_addr,
  input wire [127:0] flash_line_data,
  output reg flash_pe_busy,
  output reg flash_pe_erase,
  output reg [19:0] flash_pe_addr,
  output wire irq
);
  // ********************************************************
  // Derived timing
  // ********************************************************
  // One cycle at or below 50 MHz, two below 100, three at or above
  localparam [1:0] MISS_LAT = (CLK_MHZ <= `CFCS_MHZ_LOW) ? 2'd1 :
    (CLK_MHZ < `CFCS_MHZ_HIGH) ? 2'd2 : 2'd3;
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_MISS = 3'h1;
  localparam [2:0] ST_FILL = 3'h2;
  localparam [1:0] SQ_IDLE = 2'h0;
  localparam [1:0] SQ_RUN = 2'h1;
  localparam [1:0] SQ_SUSP = 2'h2;
  // ********************************************************
  // Control registers
  // ********************************************************
  reg cache_en;
  reg start_blk1;
  reg tm_en;
  reg pe_entry;
  reg [7:0] entry_key;
  reg viol;
  reg viol_ie;
  reg [1:0] irq_st;
  reg [1:0] irq_msk;
  reg inv_req;
  wire wr_ctrl = ce & reg_wr & (reg_addr == `CFCS_REG_CTRL);
  wire wr_entry = ce & reg_wr & (reg_addr == `CFCS_REG_ENTRY);
  wire wr_astat = ce & reg_wr & (reg_addr == `CFCS_REG_ASTAT);
  wire wr_irqst = ce & reg_wr & (reg_addr == `CFCS_REG_IRQST);
  reg viol_evt;
  reg done_evt;
  // ********************************************************
  // Cache storage
  // ********************************************************
  // Sets of WAYS lines each; the set index is one address bit wide
  localparam SETS = `CFCS_CACHE_BYTES / (WAYS * `CFCS_LINE_BYTES);
  localparam LINES = SETS * WAYS;
  reg [127:0] line_data [0:LINES-1];
  reg [15:0] line_tag [0:LINES-1];
  reg [LINES-1:0] line_valid;
  reg [2:0] age [0:LINES-1];
  reg [2:0] state;
  reg [1:0] lat_cnt;
  reg [19:0] miss_addr;
  reg [2:0] victim;
  reg [2:0] hit_way;
  reg hit;
  integer i;
  integer j;

  function [31:0] word_sel;
    input [127:0] line;
    input [1:0] idx;
    begin
      word_sel = line[idx*32 +: 32];
    end
  endfunction

  // Block 0 and 1 swap when startup area moves to block 1
  function [19:0] map_addr;
    input [19:0] a;
    input sel;
    begin
      map_addr = a;
      if (sel && (a[19:`CFCS_BLOCK_SHIFT+1] == 0)) begin
        map_addr[`CFCS_BLOCK_SHIFT] = ~a[`CFCS_BLOCK_SHIFT];
      end
    end
  endfunction

  wire [19:0] eff_addr = map_addr(fetch_addr, start_blk1);
  wire [6:0] blk_num = eff_addr[19:`CFCS_BLOCK_SHIFT];
  wire tm_block = tm_en & ~trusted_auth &
    ((blk_num == `CFCS_TM_BLK_LO) | (blk_num == `CFCS_TM_BLK_HI));
  // Lookup uses the fetch set, a fill the set of the pending miss
  wire hit_set = eff_addr[`CFCS_SET_BIT];
  wire fill_set = miss_addr[`CFCS_SET_BIT];
  wire [3:0] hit_line = {hit_set, hit_way};
  wire [3:0] fill_line = {fill_set, victim};
  // Fetches wait only during a running operation, not a suspended one
  reg [1:0] sq_state;
  wire fetch_ok = (sq_state != SQ_RUN);

  always @* begin
    hit = 1'b0;
    hit_way = 3'h0;
    victim = 3'h0;
    for (j = 0; j < WAYS; j = j + 1) begin
      if (line_valid[{hit_set, j[2:0]}] && cache_en &&
          line_tag[{hit_set, j[2:0]}] == eff_addr[19:4]) begin
        hit = 1'b1;
        hit_way = j[2:0];
      end
      if (age[{fill_set, j[2:0]}] == 3'h7) begin
        victim = j[2:0];
      end
    end
  end

  assign fetch_ready = (state == ST_IDLE) & fetch_ok;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      lat_cnt <= 2'h0;
      miss_addr <= 20'h0;
      line_valid <= {LINES{1'b0}};
      fetch_data <= 32'h0;
      fetch_valid <= 1'b0;
      flash_line_rd <= 1'b0;
      flash_line_addr <= 16'h0;
      viol_evt <= 1'b0;
      for (i = 0; i < LINES; i = i + 1) begin
        age[i] <= i[2:0];
        line_tag[i] <= 16'h0;
        line_data[i] <= 128'h0;
      end
    end else if (ce) begin
      fetch_valid <= 1'b0;
      flash_line_rd <= 1'b0;
      viol_evt <= 1'b0;
      if (inv_req) begin
        line_valid <= {LINES{1'b0}};
      end
      case (state)
        ST_IDLE: begin
          if (fetch_req && fetch_ok) begin
            if (tm_block) begin
              viol_evt <= 1'b1;
              fetch_data <= 32'h0;
              fetch_valid <= 1'b1;
            end else if (hit) begin
              fetch_data <= word_sel(line_data[hit_line],
                eff_addr[3:2]);
              fetch_valid <= 1'b1;
              for (i = 0; i < WAYS; i = i + 1) begin
                if (age[{hit_set, i[2:0]}] < age[hit_line]) begin
                  age[{hit_set, i[2:0]}] <= age[{hit_set, i[2:0]}] + 3'h1;
                end
              end
              age[hit_line] <= 3'h0;
            end else begin
              miss_addr <= eff_addr;
              flash_line_addr <= eff_addr[19:4];
              flash_line_rd <= 1'b1;
              lat_cnt <= MISS_LAT - 2'h1;
              state <= ST_MISS;
            end
          end
        end
        ST_MISS: begin
          if (lat_cnt == 2'h0) begin
            state <= ST_FILL;
          end else begin
            lat_cnt <= lat_cnt - 2'h1;
          end
        end
        ST_FILL: begin
          fetch_data <= word_sel(flash_line_data, miss_addr[3:2]);
          fetch_valid <= 1'b1;
          state <= ST_IDLE;
          if (cache_en && !inv_req) begin
            line_data[fill_line] <= flash_line_data;
            line_tag[fill_line] <= miss_addr[19:4];
            line_valid[fill_line] <= 1'b1;
            for (i = 0; i < WAYS; i = i + 1) begin
              age[{fill_set, i[2:0]}] <= age[{fill_set, i[2:0]}] + 3'h1;
            end
            age[fill_line] <= 3'h0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // ********************************************************
  // Command sequencer
  // ********************************************************
  reg [15:0] op_cnt;
  localparam [15:0] PROG_LOAD = PROG_CYCLES[15:0];
  localparam [15:0] ERASE_LOAD = ERASE_CYCLES[15:0];
  wire [23:0] area_base = `CFCS_CMD_AREA;
  wire in_area = (cmd_addr[23:16] == area_base[23:16]);
  wire cmd_hit = ce & cmd_wr & in_area;
  wire pe_ok = pe_entry;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sq_state <= SQ_IDLE;
      op_cnt <= 16'h0;
      flash_pe_busy <= 1'b0;
      flash_pe_erase <= 1'b0;
      flash_pe_addr <= 20'h0;
      done_evt <= 1'b0;
    end else if (ce) begin
      done_evt <= 1'b0;
      case (sq_state)
        SQ_IDLE: begin
          if (cmd_hit && pe_ok && cmd_data == `CFCS_CMD_PROG) begin
            flash_pe_erase <= 1'b0;
            // Align to a 128-byte programming unit
            flash_pe_addr <= {cmd_addr[19:7], 7'h0};
            op_cnt <= PROG_LOAD;
            flash_pe_busy <= 1'b1;
            sq_state <= SQ_RUN;
          end else if (cmd_hit && pe_ok &&
              cmd_data == `CFCS_CMD_ERASE) begin
            flash_pe_erase <= 1'b1;
            flash_pe_addr <= {cmd_addr[19:`CFCS_BLOCK_SHIFT],
              13'h0};
            op_cnt <= ERASE_LOAD;
            flash_pe_busy <= 1'b1;
            sq_state <= SQ_RUN;
          end
        end
        SQ_RUN: begin
          if (cmd_hit && cmd_data == `CFCS_CMD_SUSPEND) begin
            flash_pe_busy <= 1'b0;
            sq_state <= SQ_SUSP;
          end else if (op_cnt == 16'h0) begin
            flash_pe_busy <= 1'b0;
            done_evt <= 1'b1;
            sq_state <= SQ_IDLE;
          end else begin
            op_cnt <= op_cnt - 16'h1;
          end
        end
        SQ_SUSP: begin
          if (cmd_hit && cmd_data == `CFCS_CMD_RESUME) begin
            flash_pe_busy <= 1'b1;
            sq_state <= SQ_RUN;
          end
        end
        default: begin
          sq_state <= SQ_IDLE;
        end
      endcase
    end
  end
  // ********************************************************
  // Registers and interrupt
  // ********************************************************
  // Commands to the command area while idle and not in entry mode also count as access violations
  wire bad_cmd = cmd_hit & ~pe_ok & (sq_state == SQ_IDLE);
  wire viol_any = viol_evt | bad_cmd;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cache_en <= 1'b0;
      start_blk1 <= 1'b0;
      tm_en <= 1'b0;
      inv_req <= 1'b0;
      pe_entry <= 1'b0;
      entry_key <= 8'h0;
      viol <= 1'b0;
      viol_ie <= 1'b0;
      irq_st <= 2'h0;
      irq_msk <= 2'h0;
    end else if (ce) begin
      inv_req <= wr_ctrl & reg_wdata[`CFCS_CTRL_CINV];
      if (wr_ctrl) begin
        cache_en <= reg_wdata[`CFCS_CTRL_CEN];
        start_blk1 <= reg_wdata[`CFCS_CTRL_START1];
        tm_en <= reg_wdata[`CFCS_CTRL_TMEN];
      end
      // Entry bit only changes together with the right key
      if (wr_entry && reg_wdata[`CFCS_KEY_HI:`CFCS_KEY_LO] ==
          `CFCS_ENTRY_KEY) begin
        pe_entry <= reg_wdata[`CFCS_ENTRY_BIT];
        entry_key <= reg_wdata[`CFCS_KEY_HI:`CFCS_KEY_LO];
      end
      if (reg_wr && reg_addr == `CFCS_REG_AIRQ) begin
        viol_ie <= reg_wdata[`CFCS_VIOL_BIT];
      end
      if (reg_wr && reg_addr == `CFCS_REG_IRQMSK) begin
        irq_msk <= reg_wdata[1:0];
      end
      // Set wins over a clear in the same cycle
      if (viol_any) begin
        viol <= 1'b1;
      end else if (wr_astat && !reg_wdata[`CFCS_VIOL_BIT]) begin
        viol <= 1'b0;
      end
      irq_st <= (irq_st & ~(wr_irqst ? reg_wdata[1:0] : 2'h0)) |
        {viol_any, done_evt};
    end
  end

  // Not gated by the sequencer, so events still reach the CPU
  assign irq = |(irq_st & irq_msk) | (viol & viol_ie);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (ce) begin
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `CFCS_REG_CTRL: reg_rdata <= {28'h0, tm_en, start_blk1,
            1'b0, cache_en};
          `CFCS_REG_ENTRY: reg_rdata <= {16'h0, entry_key, 7'h0,
            pe_entry};
          `CFCS_REG_ASTAT: reg_rdata <= {24'h0, viol, 7'h0};
          `CFCS_REG_AIRQ: reg_rdata <= {24'h0, viol_ie, 7'h0};
          `CFCS_REG_STAT: reg_rdata <= {30'h0, sq_state};
          `CFCS_REG_IRQST: reg_rdata <= {30'h0, irq_st};
          `CFCS_REG_IRQMSK: reg_rdata <= {30'h0, irq_msk};
          `CFCS_REG_UID0: reg_rdata <= UNIQUE_ID[31:0];
          `CFCS_REG_UID1: reg_rdata <= UNIQUE_ID[63:32];
          `CFCS_REG_UID2: reg_rdata <= UNIQUE_ID[95:64];
          `CFCS_REG_UID3: reg_rdata <= UNIQUE_ID[127:96];
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

/* bench/cfcs_flash_model.sv */
// Purpose: flash array seen by the cache line port
// Assumes: line sampled two cycles after the read pulse
// Notes: data is inverted once the hold runs out
`timescale 1ns/1ps
module cfcs_flash_model (
  input wire mclk,
  input wire rst,
  input wire flash_line_rd,
  input wire [15:0] flash_line_addr,
  output wire [127:0] flash_line_data
);
  // ********************************************************
  // Array contents
  // ********************************************************
  reg [15:0] la;
  reg [1:0] hold;
  function [31:0] fw(input [19:0] a);
    fw = {12'h5a3, a};
  endfunction
  wire [127:0] line = {fw({la, 4'hc}), fw({la, 4'h8}), fw({la, 4'h4}),
    fw({la, 4'h0})};
  // Stale data never passes for a valid line
  assign flash_line_data = (hold != 2'h0) ? line : ~line;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      la <= 16'h0000;
      hold <= 2'h0;
    end else if (flash_line_rd) begin
      la <= flash_line_addr;
      hold <= 2'h3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
  end
endmodule

/* bench/cfcs_monitor.sv */
// Purpose: port checker for the flash cache and sequencer
// Assumes: one clock, asynchronous reset
// Notes: bound to the top module below
`timescale 1ns/1ps
module cfcs_monitor (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire fetch_req,
  input wire [19:0] fetch_addr,
  input wire fetch_ready,
  input wire fetch_valid,
  input wire cmd_wr,
  input wire [23:0] cmd_addr,
  input wire flash_line_rd,
  input wire [15:0] flash_line_addr,
  input wire flash_pe_busy,
  input wire flash_pe_erase,
  input wire [19:0] flash_pe_addr
);
  // ********************************************************
  // Properties
  // ********************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_hit_one_cycle: assert property (ce && fetch_req && fetch_ready |=>
    flash_line_rd || fetch_valid) else $error("fetch taken, no answer");
  chk_miss_latency: assert property (flash_line_rd |-> ##2 fetch_valid)
    else $error("miss data late");
  chk_line_pulse: assert property (flash_line_rd |=> !flash_line_rd)
    else $error("line read too long");
  // Bit 13 is left out: startup select may swap blocks 0 and 1
  chk_line_addr: assert property (flash_line_rd |->
    {flash_line_addr[15:10], flash_line_addr[8:0]} ==
    {$past(fetch_addr[19:14]), $past(fetch_addr[12:4])})
    else $error("line address wrong");
  chk_valid_pulse: assert property (fetch_valid |=> !fetch_valid)
    else $error("fetch valid too long");
  chk_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside slot");
  chk_prog_align: assert property ($rose(flash_pe_busy) && !flash_pe_erase
    |-> flash_pe_addr[6:0] == 7'h00) else $error("program unaligned");
  chk_erase_align: assert property ($rose(flash_pe_busy) && flash_pe_erase
    |-> flash_pe_addr[12:0] == 13'h0000) else $error("erase unaligned");
  chk_cmd_area: assert property (!flash_pe_busy && cmd_wr &&
    cmd_addr[23:16] != 8'h7e |=> !flash_pe_busy)
    else $error("command outside area");
endmodule
bind cfcs_top cfcs_monitor chk_u (.mclk(mclk), .rst(rst), .ce(ce),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_req(fetch_req),
  .fetch_addr(fetch_addr), .fetch_ready(fetch_ready),
  .fetch_valid(fetch_valid), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
  .flash_line_rd(flash_line_rd), .flash_line_addr(flash_line_addr),
  .flash_pe_busy(flash_pe_busy), .flash_pe_erase(flash_pe_erase),
  .flash_pe_addr(flash_pe_addr));

/* bench/tb.sv */
// Purpose: self-checking bench for the flash cache and sequencer
// Assumes: ce held high, long counts shortened to 10
// Notes: set index taken as line address bit 0
`timescale 1ns/1ps
`include "cfcs_defines.vh"
module tb;
  // ********************************************************
  // Harness
  // ********************************************************
  localparam [127:0] UID = 128'h11112222333344445555666677778888; // arbitrary
  reg mclk, rst, ce, reg_wr, reg_rd, fetch_req, cmd_wr, trusted_auth;
  reg [7:0] reg_addr, cmd_data;
  reg [31:0] reg_wdata, d;
  reg [19:0] fetch_addr;
  reg [23:0] cmd_addr;
  wire [31:0] reg_rdata, fetch_data;
  wire fetch_ready, fetch_valid, flash_line_rd, flash_pe_busy;
  wire flash_pe_erase, irq;
  wire [15:0] flash_line_addr;
  wire [127:0] flash_line_data;
  wire [19:0] flash_pe_addr;
  integer num_errors, comparisons, n, i;
  reg seen, er;
  cfcs_top #(.PROG_CYCLES(10), .ERASE_CYCLES(10), .UNIQUE_ID(UID)) dut_u (
    .mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ready(fetch_ready), .fetch_data(fetch_data),
    .fetch_valid(fetch_valid), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .trusted_auth(trusted_auth),
    .flash_line_rd(flash_line_rd), .flash_line_addr(flash_line_addr),
    .flash_line_data(flash_line_data), .flash_pe_busy(flash_pe_busy),
    .flash_pe_erase(flash_pe_erase), .flash_pe_addr(flash_pe_addr),
    .irq(irq));
  cfcs_flash_model flash_u (.mclk(mclk), .rst(rst),
    .flash_line_rd(flash_line_rd), .flash_line_addr(flash_line_addr),
    .flash_line_data(flash_line_data));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function [31:0] fw(input [19:0] a);
    fw = {12'h5a3, a};
  endfunction
  task finish_test;
    begin
      if (num_errors == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task give_up(input bad);
    if (bad) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  endtask
  task check(input [8*8:1] nm, input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  task cmd(input [23:0] a, input [7:0] c);
    begin
      @(posedge mclk);
      cmd_addr <= a;
      cmd_data <= c;
      cmd_wr <= 1'b1;
      @(posedge mclk);
      cmd_wr <= 1'b0;
    end
  endtask
  // Leaves cycles to data in n, line read in seen, data in d
  task fetch(input [19:0] a);
    begin
      @(posedge mclk);
      fetch_addr <= a;
      fetch_req <= 1'b1;
      n = 0;
      #1;
      while (fetch_ready !== 1'b1 && n < 50) begin
        @(posedge mclk);
        #1 n = n + 1;
      end
      give_up(n >= 50);
      @(posedge mclk);
      fetch_req <= 1'b0;
      n = 1;
      #1 seen = flash_line_rd;
      while (fetch_valid !== 1'b1 && n < 8) begin
        @(posedge mclk);
        #1 n = n + 1;
        seen = seen | flash_line_rd;
      end
      give_up(fetch_valid !== 1'b1);
      d = fetch_data;
    end
  endtask
  task wait_op;
    integer k;
    begin
      n = 0;
      k = 0;
      er = 1'b0;
      #1;
      while (k < 100 && !(n > 0 && flash_pe_busy === 1'b0)) begin
        if (flash_pe_busy === 1'b1) n = n + 1;
        er = er | flash_pe_erase;
        @(posedge mclk);
        #1 k = k + 1;
      end
      give_up(k >= 100);
    end
  endtask
  // ********************************************************
  // Scenarios
  // ********************************************************
  task t_regs;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        rd(`CFCS_REG_UID0 + 4 * i);
        check("uid", d, UID[32 * i +: 32]);
      end
      rd(8'h40);
      check("unmapped", d, 32'h0);
    end
  endtask
  task t_cache;
    begin
      fetch(20'hffffc);
      check("offdata", d, fw(20'hffffc));
      check("offmiss", {seen, n[3:0]}, 5'h13);
      fetch(20'hffffc);
      check("offmiss", {seen, n[3:0]}, 5'h13);
      wr(`CFCS_REG_CTRL, 32'h1);
      fetch(20'h00010);
      check("misslat", {seen, n[3:0]}, 5'h13);
      fetch(20'h0001c);
      check("hitlat", {seen, n[3:0]}, 5'h01);
      check("hitdata", d, fw(20'h0001c));
      fetch(20'h00000);
      for (i = 1; i < 8; i = i + 1) fetch(20'h00010 + 32 * i);
      fetch(20'h00010);
      check("allways", {seen, n[3:0]}, 5'h01);
      fetch(20'h00110);
      fetch(20'h00010);
      check("lrukeep", {seen, n[3:0]}, 5'h01);
      fetch(20'h00030);
      check("lruvict", {seen, n[3:0]}, 5'h13);
      fetch(20'h00000);
      check("setzero", {seen, n[3:0]}, 5'h01);
      wr(`CFCS_REG_CTRL, 32'h3);
      fetch(20'h00010);
      check("inval", {seen, n[3:0]}, 5'h13);
      wr(`CFCS_REG_CTRL, 32'h7);
      fetch(20'h00010);
      check("startup", d, fw(20'h02010));
    end
  endtask
  task t_trust;
    begin
      wr(`CFCS_REG_CTRL, 32'hb);
      wr(`CFCS_REG_AIRQ, 32'h80);
      fetch(20'h10000);
      check("tmblock", d, 32'h0);
      check("tmlat", n, 32'h1);
      rd(`CFCS_REG_ASTAT);
      check("viol", d & 32'h80, 32'h80);
      check("virq", irq, 1'b1);
      wr(`CFCS_REG_AIRQ, 32'h0);
      check("vmask", irq, 1'b0);
      wr(`CFCS_REG_ASTAT, 32'h0);
      rd(`CFCS_REG_ASTAT);
      check("vclr", d & 32'h80, 32'h0);
      @(posedge mclk);
      trusted_auth <= 1'b1;
      fetch(20'h12000);
      check("tmauth", d, fw(20'h12000));
    end
  endtask
  task t_seq;
    begin
      cmd(`CFCS_CMD_AREA, `CFCS_CMD_PROG);
      rd(`CFCS_REG_ASTAT);
      check("noentry", d & 32'h80, 32'h80);
      wr(`CFCS_REG_ENTRY, 32'h0000aa01);
      wr(`CFCS_REG_IRQMSK, 32'h1);
      cmd(24'h7d0080, `CFCS_CMD_PROG);
      cmd(24'h7e0094, `CFCS_CMD_PROG);
      wait_op;
      check("proglen", n, 11);
      check("progadr", flash_pe_addr, 32'he0080);
      @(posedge mclk);
      #1;
      check("doneirq", irq, 1'b1);
      wr(`CFCS_REG_IRQST, 32'h1);
      check("doneclr", irq, 1'b0);
      cmd(24'h7e2010, `CFCS_CMD_ERASE);
      wait_op;
      check("eraslen", {er, n[7:0]}, 9'h10b);
      check("erasadr", flash_pe_addr, 32'he2000);
      cmd(24'h7e0100, `CFCS_CMD_PROG);
      cmd(`CFCS_CMD_AREA, `CFCS_CMD_SUSPEND);
      rd(`CFCS_REG_STAT);
      check("susp", d & 32'h3, 32'h2);
      fetch(20'h00200);
      check("suspfet", d, fw(20'h00200));
      cmd(`CFCS_CMD_AREA, `CFCS_CMD_RESUME);
      rd(`CFCS_REG_STAT);
      check("resume", d & 32'h3, 32'h1);
      wait_op;
      rd(`CFCS_REG_IRQST);
      check("resdone", d & 32'h1, 32'h1);
    end
  endtask
  initial begin
    num_errors = 0;
    comparisons = 0;
    {reg_wr, reg_rd, fetch_req, cmd_wr, trusted_auth} = 5'h00;
    {reg_addr, cmd_data, reg_wdata, fetch_addr, cmd_addr} = 92'h0;
    ce = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_cache;
    t_trust;
    t_seq;
    finish_test;
  end
endmodule
